// *** rtl/par_range_cmp.sv ***
// One controller's range comparators: main window and high-to-low translation window.
// Assumes bounds are stable while requests flow; all inputs are on sys_clk_i.
`timescale 1ns/10ps
module par_range_cmp #(
  parameter int unsigned AW = par_pkg::AW
) (
  input  wire logic [AW-1:0] addr_i,     // Incoming address
  input  wire logic [AW-1:0] base_i,     // Main range base
  input  wire logic [AW-1:0] limit_i,    // Main range limit, inclusive
  input  wire logic          tr_en_i,    // Translation range enable
  input  wire logic [AW-1:0] tr_base_i,  // Translation range base
  input  wire logic [AW-1:0] tr_limit_i, // Translation range limit, inclusive
  output logic               hit_o,      // Address lies in main range
  output logic               tr_hit_o    // Address lies in translation range
);
  assign hit_o    = (addr_i >= base_i) && (addr_i <= limit_i);
  assign tr_hit_o = tr_en_i && (addr_i >= tr_base_i) && (addr_i <= tr_limit_i);
endmodule

// *** rtl/par_remap.sv ***
// Address remapping stage: tags and optionally translates mesh requests per controller.
// Assumes all inputs are on sys_clk_i and ranges are programmed before traffic starts.
//
// Notes on behaviour
// [RULE_01] Software steers config, low and high windows to the right home node.
// [RULE_02] Each of four controllers has a programmable base and limit range.
// [RULE_03] Every address is compared to all ranges; hits are modified and forwarded.
// [RULE_04] Wide mesh: quad0 sets bit 55, quad1 54, octal 53, sixteen 52.
// [RULE_05] Narrow mesh: quad0 sets bit 51, quad1 50, octal 49, sixteen 48.
// [RULE_06] Translation hit clears bits 51/47 down to 32 and sets bit 31.
// [RULE_07] Tag bits are dropped before the address reaches the chosen controller.
// [RULE_08] Config windows from 0x10_2000_0000 through 0x10_4FFF_FFFF are decoded.
// [RULE_09] High window 0x40_0000_0000 to 0x80_7FFF_FFFF is prefetchable, translatable.
// [RULE_10] Low window 0x00_6000_0000 to 0x00_7FFF_FFFF is non-prefetchable memory.
// [RULE_11] No hit forwards unchanged; several hits choose the lowest controller.
`timescale 1ns/10ps
module par_remap #(
  parameter int unsigned NCTRL = par_pkg::NCTRL,
  parameter int unsigned AW    = par_pkg::AW
) (
  input  wire logic                sys_clk_i,      // System clock
  input  wire logic                reset_n_i,      // Synchronous reset, active low
  input  wire logic                clk_en_i,       // Freezes all state while low unless reset is asserted
  input  wire logic                wide_mode_i,    // High selects 52-bit mesh, low 48-bit
  input  wire logic [NCTRL*AW-1:0] base_i,         // Per-controller range bases
  input  wire logic [NCTRL*AW-1:0] limit_i,        // Per-controller range limits
  input  wire logic [NCTRL-1:0]    tr_en_i,        // Per-controller translation enables
  input  wire logic [NCTRL*AW-1:0] tr_base_i,      // Per-controller translation bases
  input  wire logic [NCTRL*AW-1:0] tr_limit_i,     // Per-controller translation limits
  input  wire logic                req_valid_i,    // Mesh request valid
  input  wire logic [AW-1:0]       req_addr_i,     // Mesh request address
  output logic                     fwd_valid_o,    // Request to noncoherent interconnect
  output logic [AW-1:0]            fwd_addr_o,     // Tagged or translated address
  output logic                     fwd_hit_o,      // A controller range matched
  output logic                     fwd_prefetch_o, // Target is prefetchable space
  output logic [1:0]               fwd_window_o,   // Fixed window class of the request
  output logic [NCTRL-1:0]         ctrl_valid_o,   // Per-controller delivery strobe
  output logic [AW-1:0]            ctrl_addr_o     // Address seen by the controller
);
  logic [NCTRL-1:0] hit_w;
  logic [NCTRL-1:0] tr_hit_w;
  logic [NCTRL-1:0] win_w;
  logic             any_hit_w;
  logic             sel_tr_w;
  logic [AW-1:0]    xlat_w;
  logic [AW-1:0]    tag_w;
  logic [AW-1:0]    mod_w;
  logic [AW-1:0]    strip_w;
  par_pkg::par_win_t win_cls_w;
  logic             in_cfg_w;
  logic             in_low_w;
  logic             in_high_w;

  logic              valid_q;
  logic [AW-1:0]     addr_q;
  logic              hit_q;
  logic              pref_q;
  logic [1:0]        win_q;
  logic [NCTRL-1:0]  cv_q;
  logic [AW-1:0]     caddr_q;

  genvar g;
  generate
    for (g = 0; g < NCTRL; g++) begin : g_cmp
      par_range_cmp #(.AW(AW)) u_cmp (
        .addr_i     (req_addr_i),
        .base_i     (base_i[g*AW +: AW]),
        .limit_i    (limit_i[g*AW +: AW]),
        .tr_en_i    (tr_en_i[g]),
        .tr_base_i  (tr_base_i[g*AW +: AW]),
        .tr_limit_i (tr_limit_i[g*AW +: AW]),
        .hit_o      (hit_w[g]),           // RULE_02
        .tr_hit_o   (tr_hit_w[g])
      );
    end
  endgenerate

  // Lowest-numbered controller wins, so one tag bit at most is ever set.
  function automatic logic [NCTRL-1:0] first_one(input logic [NCTRL-1:0] v);
    logic [NCTRL-1:0] r;
    r = '0;
    for (int i = NCTRL - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = '0;
        r[i] = 1'b1;
      end
    end
    return r;
  endfunction

  // Clears the upper address field and sets the low-4GB marker bit.
  function automatic logic [AW-1:0] to_low(input logic [AW-1:0] a, input logic wide);
    logic [AW-1:0] r;
    r = a;
    for (int b = par_pkg::TR_LO_BIT; b <= par_pkg::TR_HI_52; b++) begin
      if (wide || b <= par_pkg::TR_HI_48) begin
        r[b] = 1'b0;
      end
    end
    r[par_pkg::TR_SET_BIT] = 1'b1;
    return r;
  endfunction

  // Tag bit for controller k sits at the top of the tag nibble, counting downward.
  function automatic logic [AW-1:0] tag_of(input logic [NCTRL-1:0] w, input logic wide);
    logic [AW-1:0] r;
    int unsigned   lo;
    r  = '0;
    lo = wide ? par_pkg::TAG_LO_52 : par_pkg::TAG_LO_48;
    for (int k = 0; k < NCTRL; k++) begin
      if (w[k]) begin
        r[lo + NCTRL - 1 - k] = 1'b1;
      end
    end
    return r;
  endfunction

  assign any_hit_w = |hit_w;                                     // RULE_03
  assign win_w     = first_one(hit_w);                           // RULE_11
  assign sel_tr_w  = |(win_w & tr_hit_w);                        // RULE_06
  assign xlat_w    = sel_tr_w ? to_low(req_addr_i, wide_mode_i) : req_addr_i; // RULE_06
  assign tag_w     = tag_of(win_w, wide_mode_i);                 // RULE_04 RULE_05
  // Bits at and above the native width are cleared before tagging, then tag is ORed in.
  assign strip_w   = wide_mode_i ? (xlat_w & ~({AW{1'b1}} << par_pkg::NATIVE_W52))
                                 : (xlat_w & ~({AW{1'b1}} << par_pkg::NATIVE_W48)); // RULE_07
  assign mod_w     = any_hit_w ? (strip_w | tag_w) : req_addr_i; // RULE_11

  // Window class only informs the downstream attribute path; it does not block a hit.
  assign in_cfg_w  = (req_addr_i >= par_pkg::CFG_BASE) && (req_addr_i <= par_pkg::CFG_LAST); // RULE_08
  assign in_low_w  = (req_addr_i >= par_pkg::LOW_BASE) && (req_addr_i <= par_pkg::LOW_LAST); // RULE_10
  assign in_high_w = (req_addr_i >= par_pkg::HIGH_BASE) && (req_addr_i <= par_pkg::HIGH_LAST);
  assign win_cls_w = in_cfg_w  ? par_pkg::PAR_WIN_CFG  :
                     in_low_w  ? par_pkg::PAR_WIN_LOW  :
                     in_high_w ? par_pkg::PAR_WIN_HIGH :
                                 par_pkg::PAR_WIN_NONE;

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      valid_q <= 1'b0;
      addr_q  <= '0;
      hit_q   <= 1'b0;
      pref_q  <= 1'b0;
      win_q   <= par_pkg::PAR_WIN_NONE;
      cv_q    <= '0;
      caddr_q <= '0;
    end else if (clk_en_i) begin
      valid_q <= req_valid_i;                                     // RULE_03
      addr_q  <= mod_w;
      hit_q   <= req_valid_i && any_hit_w;
      // High window stays prefetchable unless carved into the low 4GB.
      pref_q  <= (win_cls_w == par_pkg::PAR_WIN_HIGH) && !sel_tr_w; // RULE_09
      win_q   <= win_cls_w;
      cv_q    <= req_valid_i ? win_w : '0;
      caddr_q <= strip_w;                                         // RULE_07
    end
  end

  assign fwd_valid_o    = valid_q;
  assign fwd_addr_o     = addr_q;
  assign fwd_hit_o      = hit_q;
  assign fwd_prefetch_o = pref_q;
  assign fwd_window_o   = win_q;
  assign ctrl_valid_o   = cv_q;
  assign ctrl_addr_o    = caddr_q;
endmodule

// *** shared/par_pkg.sv ***
// Constants for the address remapping stage between the mesh and the controller path.
// Assumes one system clock; controller range bounds are supplied by software as plain ports, fixed window bounds are constants here.
package par_pkg;
  localparam int unsigned NCTRL      = 4;
  localparam int unsigned AW         = 56;
  localparam int unsigned NATIVE_W52 = 52;
  localparam int unsigned NATIVE_W48 = 48;
  localparam int unsigned TAG_LO_52  = 52;
  localparam int unsigned TAG_LO_48  = 48;
  localparam int unsigned TR_LO_BIT  = 32;
  localparam int unsigned TR_HI_52   = 51;
  localparam int unsigned TR_HI_48   = 47;
  localparam int unsigned TR_SET_BIT = 31;
  // Fixed windows of the controller path.
  localparam logic [AW-1:0] CFG_BASE  = 56'h00_0010_2000_0000;
  localparam logic [AW-1:0] CFG_LAST  = 56'h00_0010_4FFF_FFFF;
  localparam logic [AW-1:0] LOW_BASE  = 56'h00_0000_6000_0000;
  localparam logic [AW-1:0] LOW_LAST  = 56'h00_0000_7FFF_FFFF;
  localparam logic [AW-1:0] HIGH_BASE = 56'h00_0040_0000_0000;
  localparam logic [AW-1:0] HIGH_LAST = 56'h00_0080_7FFF_FFFF;
  typedef enum logic [1:0] {
    PAR_WIN_NONE,
    PAR_WIN_CFG,
    PAR_WIN_LOW,
    PAR_WIN_HIGH
  } par_win_t;
endpackage

// *** sim/par_ctrl_model.sv ***
// Controller-side model: keeps the last address each controller was handed.
// Assumes strobes count only on enabled clock edges.
`timescale 1ns/10ps
module par_ctrl_model (
  input  wire logic        sys_clk_i,    // Clock
  input  wire logic        clk_en_i,     // Enable
  input  wire logic [3:0]  ctrl_valid_i, // Strobes
  input  wire logic [55:0] ctrl_addr_i,  // Delivered address
  output logic [3:0][55:0] got_addr_o    // Last address per controller
);
  always_ff @(posedge sys_clk_i) begin
    for (int k = 0; k < 4; k++) begin
      if (clk_en_i && ctrl_valid_i[k]) got_addr_o[k] <= ctrl_addr_i;
    end
  end
endmodule

// *** sim/par_remap_checker.sv ***
// Checker for the address remapping stage, bound to its top module.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/10ps
module par_remap_checker (
  input wire logic        sys_clk_i,    // Clock
  input wire logic        reset_n_i,    // Reset
  input wire logic        clk_en_i,     // Enable
  input wire logic        wide_mode_i,  // Mode
  input wire logic        req_valid_i,  // Valid in
  input wire logic [55:0] req_addr_i,   // Address in
  input wire logic        fwd_valid_o,  // Valid out
  input wire logic [55:0] fwd_addr_o,   // Address out
  input wire logic        fwd_hit_o,    // Hit
  input wire logic [3:0]  ctrl_valid_o, // Strobes
  input wire logic [55:0] ctrl_addr_o   // Controller address
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  // Strobe bit 0 owns the highest tag bit, so the order is reversed.
  wire logic [3:0] tag_w = {ctrl_valid_o[0], ctrl_valid_o[1], ctrl_valid_o[2], ctrl_valid_o[3]};
  valid_lat_a: assert property (clk_en_i |=> fwd_valid_o == $past(req_valid_i))
    else $error("Bad latency.");
  one_ctrl_a: assert property ($onehot0(ctrl_valid_o))
    else $error("Several strobes.");
  hit_strobe_a: assert property ((fwd_hit_o == (|ctrl_valid_o))
    && (!fwd_hit_o || fwd_valid_o)) else $error("Hit and strobe differ.");
  miss_pass_a: assert property (clk_en_i && req_valid_i
    |=> fwd_hit_o || fwd_addr_o == $past(req_addr_i)) else $error("Miss altered.");
  wide_tag_a: assert property (clk_en_i && wide_mode_i
    |=> !fwd_hit_o || fwd_addr_o[55:52] == tag_w) else $error("Bad wide tag.");
  narrow_tag_a: assert property (clk_en_i && !wide_mode_i
    |=> !fwd_hit_o || fwd_addr_o[55:48] == {4'h0, tag_w}) else $error("Bad narrow tag.");
  wide_strip_a: assert property (clk_en_i && wide_mode_i
    |=> !fwd_hit_o || ctrl_addr_o == {4'h0, fwd_addr_o[51:0]}) else $error("Wide tag kept.");
  narrow_strip_a: assert property (clk_en_i && !wide_mode_i
    |=> !fwd_hit_o || ctrl_addr_o == {8'h00, fwd_addr_o[47:0]}) else $error("Narrow tag kept.");
  cover property (fwd_hit_o && ctrl_valid_o[3]);
  cover property (fwd_valid_o && !fwd_hit_o);
  cover property (!clk_en_i ##1 fwd_hit_o);
endmodule
bind par_remap par_remap_checker u_chk (.*);

// *** sim/par_remap_tb.sv ***
// Self-checking bench for the remapping stage and its controller-side model.
// Assumes the checker binds itself; one 100 MHz clock.
`timescale 1ns/10ps
module par_remap_tb;
  typedef struct packed {
    logic w; logic [55:0] a; logic [2:0] k; logic t; logic [1:0] v;
  } par_row_t;
  logic sys_clk_i = 0, reset_n_i = 0, clk_en_i = 1, wide_mode_i = 0, req_valid_i = 0;
  logic fwd_valid_o, fwd_hit_o, fwd_prefetch_o;
  logic [1:0] fwd_window_o;
  logic [3:0] ctrl_valid_o, tr_en_i = 4'h8;
  logic [55:0] req_addr_i = 0, fwd_addr_o, ctrl_addr_o, c, f;
  logic [3:0][55:0] got;
  logic [223:0] base_i, limit_i, tr_base_i, tr_limit_i;
  int err_total = 0, n_tests = 0;
  par_row_t r;
  // Controller 2 overlaps the start of controller 3 so the priority shows.
  assign base_i = {56'h40_0000_0000, 56'h40_0000_0000, 56'h6000_0000, 56'h10_2000_0000};
  assign limit_i = {56'h80_7FFF_FFFF, 56'h40_0FFF_FFFF, 56'h7FFF_FFFF, 56'h10_2FFF_FFFF};
  assign tr_base_i = {56'h80_0000_0000, 168'h0};
  assign tr_limit_i = {56'h80_7FFF_FFFF, 168'h0};
  par_row_t rows [10] = '{
    '{1'h1, 56'h10_2000_0000, 3'h0, 1'h0, 2'h1}, '{1'h0, 56'h10_2FFF_FFFF, 3'h0, 1'h0, 2'h1},
    '{1'h1, 56'h6000_0000, 3'h1, 1'h0, 2'h2}, '{1'h0, 56'h7FFF_FFFF, 3'h1, 1'h0, 2'h2},
    '{1'h1, 56'h40_0000_1000, 3'h2, 1'h0, 2'h3}, '{1'h0, 56'h40_1000_0000, 3'h3, 1'h0, 2'h3},
    '{1'h1, 56'h80_0000_0000, 3'h3, 1'h1, 2'h3}, '{1'h0, 56'h80_7FFF_FFFF, 3'h3, 1'h1, 2'h3},
    '{1'h1, 56'h5FFF_FFFF, 3'h4, 1'h0, 2'h0}, '{1'h0, 56'h10_5000_0000, 3'h4, 1'h0, 2'h0}};
  par_remap dut (.*);
  par_ctrl_model model (.sys_clk_i, .clk_en_i, .ctrl_valid_i(ctrl_valid_o),
    .ctrl_addr_i(ctrl_addr_o), .got_addr_o(got));
  always #5 sys_clk_i = ~sys_clk_i;
  task automatic chk(input string n, input logic [55:0] e, input logic [55:0] s);
    n_tests++;
    if (s !== e) begin
      $display("BAD %s exp %h got %h", n, e, s);
      err_total++;
    end
  endtask
  task automatic step;
    @(posedge sys_clk_i);
    #1;
  endtask
  task automatic give_verdict;
    $display("mismatches %0d comparisons %0d", err_total, n_tests);
    if (err_total == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #20000;
    err_total++;
    give_verdict;
  end
  initial begin
    step;
    step;
    chk("reset", 0, {fwd_valid_o, ctrl_valid_o});
    reset_n_i = 1;
    step;
    req_valid_i = 1;
    foreach (rows[i]) begin
      r = rows[i];
      wide_mode_i = r.w;
      req_addr_i = r.a;
      step;
      c = r.w ? {4'h0, r.a[51:0]} : {8'h00, r.a[47:0]};
      if (r.t) c = {24'h00_0000, 1'b1, c[30:0]};
      f = (r.k == 3'h4) ? r.a : c | (56'h1 << ((r.w ? 55 : 51) - r.k));
      chk("fwd addr", f, fwd_addr_o);
      chk("strobes", (r.k == 3'h4) ? 0 : 4'h1 << r.k, ctrl_valid_o);
      if (r.k != 3'h4) chk("ctrl addr", c, ctrl_addr_o);
      chk("class", {r.v, r.v == 2'h3 && !r.t, r.k != 3'h4, 1'b1},
        {fwd_window_o, fwd_prefetch_o, fwd_hit_o, fwd_valid_o});
    end
    clk_en_i = 0;
    req_addr_i = 56'h6000_0000;
    step;
    chk("frozen", f, fwd_addr_o);
    clk_en_i = 1;
    req_valid_i = 0;
    step;
    chk("idle", 0, {fwd_valid_o, ctrl_valid_o});
    chk("model", 56'hFFFF_FFFF, got[3]);
    req_valid_i = 1;
    reset_n_i = 0;
    step;
    chk("reset again", 0, {fwd_valid_o, ctrl_valid_o});
    give_verdict;
  end
endmodule
